/* rtl/mdci_map.vh */
/*
  constants for the drive command interface: register numbers, function
  codes, exception codes, source-select values and command word fields.
  assumes it is included by its bare name from the rtl files.
*/
`ifndef MDCI_MAP_VH
`define MDCI_MAP_VH

// register numbers as carried in the request, zero based
`define MDCI_ADDR_LOGIC_CMD 16'h2000
`define MDCI_ADDR_SPEED_REF 16'h2001
`define MDCI_REG_COUNT 16'h0002

// reset values of the two registers
`define MDCI_RST_LOGIC_CMD 16'h0000
`define MDCI_RST_SPEED_REF 16'h0000

// supported function codes
`define MDCI_FC_READ_HOLD 8'h03
`define MDCI_FC_WRITE_SINGLE 8'h06
`define MDCI_FC_WRITE_MULTI 8'h10

// exception codes returned in the answer
`define MDCI_EXC_NONE 8'h00
`define MDCI_EXC_ILLEGAL_FUNC 8'h01
`define MDCI_EXC_ILLEGAL_ADDR 8'h02
`define MDCI_EXC_ILLEGAL_VALUE 8'h03

// source-select values
`define MDCI_SRC_SERIAL 8'h05
`define MDCI_OUT_SEL_COMM 8'h14

// firmware revision times one hundred, 4.01 and later drive the aux outputs
`define MDCI_FRN_AUX_MIN 16'h0191

// command word field positions
`define MDCI_BIT_STOP 0
`define MDCI_BIT_START 1
`define MDCI_BIT_JOG 2
`define MDCI_BIT_FAULT_CLR 3
`define MDCI_DIR_LSB 4
`define MDCI_BIT_OPTO1 6
`define MDCI_BIT_OPTO2 7
`define MDCI_ACC_LSB 8
`define MDCI_DEC_LSB 10
`define MDCI_FREQ_LSB 12
`define MDCI_BIT_RELAY 15

// two-bit select codes of the direction and rate fields
`define MDCI_SEL_NONE 2'b00
`define MDCI_SEL_ONE 2'b01
`define MDCI_SEL_TWO 2'b10
`define MDCI_SEL_HOLD 2'b11

`endif

/* rtl/mdci_cmd_decode.v */
/*
  decodes an accepted logic command word into request pulses and held
  selections for the drive control logic.
  assumes cmd_load is a one-cycle strobe in the clk domain.
*/
`include "mdci_map.vh"

module mdci_cmd_decode (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire cmd_load,
  input wire [15:0] cmd_word,
  output reg stop_req,
  output reg start_req,
  output reg jog_req,
  output reg fault_clear_req,
  output reg dir_forward,
  output reg dir_reverse,
  output reg accel_rate2,
  output reg decel_rate2,
  output reg [2:0] freq_source
);

  // 01 selects rate one, 10 rate two, 00 and 11 keep the selection
  function rate_pick;
    input [1:0] code;
    input current;
    begin
      case (code)
        `MDCI_SEL_ONE: rate_pick = 1'b0;
        `MDCI_SEL_TWO: rate_pick = 1'b1;
        default: rate_pick = current;
      endcase
    end
  endfunction

  wire [1:0] dir_code = cmd_word[`MDCI_DIR_LSB+1:`MDCI_DIR_LSB];
  wire [2:0] freq_code = cmd_word[`MDCI_FREQ_LSB+2:`MDCI_FREQ_LSB];

  // request bits pulse once per accepted word, selections hold between words
  always @(posedge clk) begin
    if (!resetn) begin
      stop_req <= 1'b0;
      start_req <= 1'b0;
      jog_req <= 1'b0;
      fault_clear_req <= 1'b0;
      dir_forward <= 1'b0;
      dir_reverse <= 1'b0;
      accel_rate2 <= 1'b0;
      decel_rate2 <= 1'b0;
      freq_source <= 3'h0;
    end else if (ce) begin
      stop_req <= cmd_load & cmd_word[`MDCI_BIT_STOP];
      start_req <= cmd_load & cmd_word[`MDCI_BIT_START];
      jog_req <= cmd_load & cmd_word[`MDCI_BIT_JOG];
      fault_clear_req <= cmd_load & cmd_word[`MDCI_BIT_FAULT_CLR];
      if (cmd_load) begin
        if (dir_code == `MDCI_SEL_ONE || dir_code == `MDCI_SEL_TWO) begin
          dir_forward <= (dir_code == `MDCI_SEL_ONE);
          dir_reverse <= (dir_code == `MDCI_SEL_TWO);
        end
        accel_rate2 <= rate_pick(cmd_word[`MDCI_ACC_LSB+1:`MDCI_ACC_LSB], accel_rate2);
        decel_rate2 <= rate_pick(cmd_word[`MDCI_DEC_LSB+1:`MDCI_DEC_LSB], decel_rate2);
        if (freq_code != 3'h0) begin
          freq_source <= freq_code;
        end
      end
    end
  end

endmodule // mdci_cmd_decode

/* rtl/mdci_aux_out.v */
/*
  drives the two opto outputs and the changeover relay from the stored
  command word when each output is assigned to the serial port and the firmware revision is 4.01 or later.
  assumes selects and firmware revision are quasi-static inputs on clk.
*/
`include "mdci_map.vh"

module mdci_aux_out #(
  parameter N_OUT = 3
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [N_OUT-1:0] cmd_bits,
  input wire [8*N_OUT-1:0] out_selects,
  input wire [15:0] firmware_revision,
  output wire [N_OUT-1:0] aux_out
);

  // older firmware ignores these command bits entirely
  wire fw_has_aux = (firmware_revision >= `MDCI_FRN_AUX_MIN);
  reg [N_OUT-1:0] aux_reg;

  genvar k;
  generate
    for (k = 0; k < N_OUT; k = k + 1) begin : g_out
      // an output follows its bit only while its select names the port
      always @(posedge clk) begin
        if (!resetn) begin
          aux_reg[k] <= 1'b0;
        end else if (ce) begin
          aux_reg[k] <= fw_has_aux & (out_selects[8*k+7:8*k] == `MDCI_OUT_SEL_COMM) & cmd_bits[k];
        end
      end
    end
  endgenerate

  assign aux_out = aux_reg;

endmodule // mdci_aux_out

/* rtl/mdci_cmd_if.v */
/*
  drive command interface: takes decoded Modbus RTU requests (function,
  register number, quantity, data words), keeps the logic command and
  speed reference registers and answers reads, writes and exceptions.
  reads walk the register numbers upward and return one word per cycle.
  a write refused by its source select still gets a normal answer, it only
  leaves the register and the decoded outputs alone.
  exception answers leave both registers and every decoded output untouched.
  every answer is a single-cycle RSP_VALID pulse with the code held after.
  all state holds while CE is low; reset does not wait for CE.
  assumes framing, CRC and node addressing are done upstream and that all
  inputs are synchronous to CLK.
*/
`include "mdci_map.vh"

module mdci_cmd_if (
  input wire CLK,
  input wire RESETN,
  input wire CE,
  input wire REQ_VALID,
  output wire REQ_READY,
  input wire [7:0] REQ_FUNC,
  input wire [15:0] REQ_ADDR,
  input wire [15:0] REQ_QTY,
  input wire [15:0] REQ_DATA,
  input wire WR_VALID,
  output wire WR_READY,
  input wire [15:0] WR_DATA,
  output wire RD_VALID,
  output wire [15:0] RD_DATA,
  output wire RSP_VALID,
  output wire RSP_EXCEPTION,
  output wire [7:0] RSP_CODE,
  input wire [7:0] START_SOURCE_SELECT,
  input wire [7:0] SPEED_REFERENCE_SELECT,
  input wire [7:0] OPTO1_OUTPUT_SELECT,
  input wire [7:0] OPTO2_OUTPUT_SELECT,
  input wire [7:0] RELAY_OUTPUT_SELECT,
  input wire [15:0] FIRMWARE_REVISION,
  output wire [15:0] LOGIC_COMMAND,
  output wire [15:0] SPEED_REFERENCE,
  output wire CMD_STROBE,
  output wire STOP_REQ,
  output wire START_REQ,
  output wire JOG_REQ,
  output wire FAULT_CLEAR_REQ,
  output wire DIR_FORWARD,
  output wire DIR_REVERSE,
  output wire ACCEL_RATE2,
  output wire DECEL_RATE2,
  output wire [2:0] FREQ_SOURCE,
  output wire OPTO1_OUT,
  output wire OPTO2_OUT,
  output wire RELAY_OUT
);

  // frame sequencer states: wait, stream read words, take write words, answer
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_READ = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  // request check: function first, then quantity, then address range
  function [7:0] req_check;
    input [7:0] func;
    input [15:0] addr;
    input [15:0] qty;
    reg [16:0] last;
    begin
      last = {1'b0, addr} + {1'b0, qty} - 17'h00001;
      if (func != `MDCI_FC_READ_HOLD && func != `MDCI_FC_WRITE_SINGLE &&
          func != `MDCI_FC_WRITE_MULTI) begin
        req_check = `MDCI_EXC_ILLEGAL_FUNC;
      end else if (qty == 16'h0000 || qty > `MDCI_REG_COUNT) begin
        req_check = `MDCI_EXC_ILLEGAL_VALUE;
      end else if (addr < `MDCI_ADDR_LOGIC_CMD || last > {1'b0, `MDCI_ADDR_SPEED_REF}) begin
        req_check = `MDCI_EXC_ILLEGAL_ADDR;
      end else begin
        req_check = `MDCI_EXC_NONE;
      end
    end
  endfunction

  // sequencer state and frame bookkeeping
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] addr_reg;
  reg [15:0] addr_next;
  reg [15:0] left_reg;
  reg [15:0] left_next;

  // answer registers towards the framer
  reg rd_valid_reg;
  reg rd_valid_next;
  reg [15:0] rd_data_reg;
  reg [15:0] rd_data_next;
  reg rsp_valid_reg;
  reg rsp_valid_next;
  reg [7:0] rsp_code_reg;
  reg [7:0] rsp_code_next;

  // holding registers and the command strobe
  reg [15:0] cmd_reg;
  reg [15:0] ref_reg;
  reg cmd_strobe_reg;

  // write port, steered by the sequencer
  reg wr_en;
  reg [15:0] wr_addr;
  reg [15:0] wr_data;

  // one decoded RTU request or data word per edge with valid and ready high
  wire req_take = REQ_VALID & REQ_READY;
  wire wr_take = WR_VALID & WR_READY;
  // a single write always carries one word
  wire [15:0] req_qty = (REQ_FUNC == `MDCI_FC_WRITE_SINGLE) ? 16'h0001 : REQ_QTY;
  // exception code of the request on the bus, zero when it can be served
  wire [7:0] req_exc = req_check(REQ_FUNC, REQ_ADDR, req_qty);

  // writes gated by the owning source select
  wire cmd_load = wr_en & (wr_addr == `MDCI_ADDR_LOGIC_CMD) &
                  (START_SOURCE_SELECT == `MDCI_SRC_SERIAL);
  wire ref_load = wr_en & (wr_addr == `MDCI_ADDR_SPEED_REF) &
                  (SPEED_REFERENCE_SELECT == `MDCI_SRC_SERIAL);

  // handshakes: requests in idle, data words in the write phase
  assign REQ_READY = CE & (state_reg == ST_IDLE);
  assign WR_READY = CE & (state_reg == ST_WRITE);

  // frame sequencer and write-port selection
  always @* begin
    state_next = state_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    rsp_valid_next = 1'b0;
    rsp_code_next = rsp_code_reg;
    wr_en = 1'b0;
    wr_addr = REQ_ADDR;
    wr_data = REQ_DATA;
    case (state_reg)
      ST_IDLE: begin
        if (req_take) begin
          addr_next = REQ_ADDR;
          left_next = req_qty;
          if (req_exc != `MDCI_EXC_NONE) begin
            rsp_valid_next = 1'b1;
            rsp_code_next = req_exc;
          end else begin
            rsp_code_next = `MDCI_EXC_NONE;
            case (REQ_FUNC)
              `MDCI_FC_WRITE_SINGLE: begin
                wr_en = 1'b1;
                rsp_valid_next = 1'b1;
              end
              `MDCI_FC_READ_HOLD: begin
                state_next = ST_READ;
              end
              default: begin
                state_next = ST_WRITE;
              end
            endcase
          end
        end
      end
      ST_READ: begin
        rd_valid_next = 1'b1;
        rd_data_next = (addr_reg == `MDCI_ADDR_LOGIC_CMD) ? cmd_reg : ref_reg;
        addr_next = addr_reg + 16'h0001;
        left_next = left_reg - 16'h0001;
        if (left_reg == 16'h0001) begin
          state_next = ST_DONE;
        end
      end
      ST_WRITE: begin
        wr_addr = addr_reg;
        wr_data = WR_DATA;
        if (wr_take) begin
          wr_en = 1'b1;
          addr_next = addr_reg + 16'h0001;
          left_next = left_reg - 16'h0001;
          if (left_reg == 16'h0001) begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        rsp_valid_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer and answer flip-flops
  always @(posedge CLK) begin
    if (!RESETN) begin
      state_reg <= ST_IDLE;
      addr_reg <= 16'h0000;
      left_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 16'h0000;
      rsp_valid_reg <= 1'b0;
      rsp_code_reg <= `MDCI_EXC_NONE;
    end else if (CE) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      left_reg <= left_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_code_reg <= rsp_code_next;
    end
  end

  // the two holding registers, value in tenths of a hertz for the reference
  always @(posedge CLK) begin
    if (!RESETN) begin
      cmd_reg <= `MDCI_RST_LOGIC_CMD;
      ref_reg <= `MDCI_RST_SPEED_REF;
      cmd_strobe_reg <= 1'b0;
    end else if (CE) begin
      cmd_strobe_reg <= cmd_load;
      if (cmd_load) begin
        cmd_reg <= wr_data;
      end
      if (ref_load) begin
        ref_reg <= wr_data;
      end
    end
  end

  // command word decoder, fed from the same write port as the register
  mdci_cmd_decode u_decode (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .cmd_load(cmd_load),
    .cmd_word(wr_data),
    .stop_req(STOP_REQ),
    .start_req(START_REQ),
    .jog_req(JOG_REQ),
    .fault_clear_req(FAULT_CLEAR_REQ),
    .dir_forward(DIR_FORWARD),
    .dir_reverse(DIR_REVERSE),
    .accel_rate2(ACCEL_RATE2),
    .decel_rate2(DECEL_RATE2),
    .freq_source(FREQ_SOURCE)
  );

  // aux outputs: index 0 opto 1, index 1 opto 2, index 2 relay
  wire [2:0] aux_out;

  mdci_aux_out #(
    .N_OUT(3)
  ) u_aux (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .cmd_bits({cmd_reg[`MDCI_BIT_RELAY], cmd_reg[`MDCI_BIT_OPTO2], cmd_reg[`MDCI_BIT_OPTO1]}),
    .out_selects({RELAY_OUTPUT_SELECT, OPTO2_OUTPUT_SELECT, OPTO1_OUTPUT_SELECT}),
    .firmware_revision(FIRMWARE_REVISION),
    .aux_out(aux_out)
  );

  assign OPTO1_OUT = aux_out[0];
  assign OPTO2_OUT = aux_out[1];
  assign RELAY_OUT = aux_out[2];

  // read and answer views of the flip-flops
  assign RD_VALID = rd_valid_reg;
  assign RD_DATA = rd_data_reg;
  assign RSP_VALID = rsp_valid_reg;
  assign RSP_EXCEPTION = (rsp_code_reg != `MDCI_EXC_NONE);
  assign RSP_CODE = rsp_code_reg;

  // stored registers and the command strobe
  assign LOGIC_COMMAND = cmd_reg;
  assign SPEED_REFERENCE = ref_reg;
  assign CMD_STROBE = cmd_strobe_reg;

endmodule // mdci_cmd_if

/* bench/mdci_master.sv */
/*
  partner model: Modbus RTU master, frames already decoded into fields.
  assumes xfer is called just after a rising clock edge.
*/
module mdci_master (
  input wire clk,
  output logic req_valid,
  input wire req_ready,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_qty,
  output logic [15:0] req_data,
  output logic wr_valid,
  input wire wr_ready,
  output logic [15:0] wr_data,
  input wire rd_valid,
  input wire [15:0] rd_data,
  input wire rsp_valid,
  input wire [7:0] rsp_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rd [2];
  logic [7:0] code;
  int nrd;
  initial {req_valid, req_func, req_addr, req_qty, req_data, wr_valid, wr_data} = '0;
  // hold a request until taken, feed its words, collect the answer
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, q, d0, d1);
    int n;
    int w;
    n = 0;
    w = 0;
    nrd = 0;
    code = 8'hff;
    req_valid <= 1'b1;
    req_func <= f;
    req_addr <= a;
    req_qty <= q;
    req_data <= d0;
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    wr_valid <= (f == 8'h10);
    wr_data <= d0;
    for (n = 0; n < 20 && code == 8'hff; n++) begin
      @(posedge clk);
      if (rd_valid === 1'b1 && nrd < 2) rd[nrd++] = rd_data;
      if (wr_valid && wr_ready === 1'b1) begin
        w++;
        wr_data <= d1;
        wr_valid <= (w < q);
      end
      if (rsp_valid === 1'b1) code = rsp_code;
    end
    wr_valid <= 1'b0;
  endtask
endmodule // mdci_master

/* bench/mdci_cmd_if_chk.sv */
/*
  checker of the drive command interface, seeing only its top ports.
  assumes one clock and a synchronous active-low reset.
*/
module mdci_cmd_if_chk (
  input wire CLK,
  input wire RESETN,
  input wire CE,
  input wire REQ_VALID,
  input wire REQ_READY,
  input wire [7:0] REQ_FUNC,
  input wire RSP_VALID,
  input wire [7:0] RSP_CODE,
  input wire [7:0] START_SOURCE_SELECT,
  input wire [7:0] SPEED_REFERENCE_SELECT,
  input wire [7:0] OPTO1_OUTPUT_SELECT,
  input wire [7:0] OPTO2_OUTPUT_SELECT,
  input wire [7:0] RELAY_OUTPUT_SELECT,
  input wire [15:0] FIRMWARE_REVISION,
  input wire [15:0] LOGIC_COMMAND,
  input wire [15:0] SPEED_REFERENCE,
  input wire CMD_STROBE,
  input wire STOP_REQ,
  input wire START_REQ,
  input wire JOG_REQ,
  input wire FAULT_CLEAR_REQ,
  input wire ACCEL_RATE2,
  input wire [2:0] FREQ_SOURCE,
  input wire OPTO1_OUT,
  input wire OPTO2_OUT,
  input wire RELAY_OUT
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // what the three aux outputs should show one cycle later
  wire [2:0] aux_want = {3{FIRMWARE_REVISION >= 16'h0191}} & {OPTO1_OUTPUT_SELECT == 8'h14 && LOGIC_COMMAND[6],
    OPTO2_OUTPUT_SELECT == 8'h14 && LOGIC_COMMAND[7], RELAY_OUTPUT_SELECT == 8'h14 && LOGIC_COMMAND[15]};
  a_func_refused: assert property (REQ_VALID && REQ_READY && !(REQ_FUNC inside {8'h03, 8'h06, 8'h10})
    |=> RSP_VALID && RSP_CODE == 8'h01) else $error("bad function not refused");
  a_cmd_gate: assert property ($changed(LOGIC_COMMAND) |-> $past(START_SOURCE_SELECT) == 8'h05)
    else $error("command stored while locked");
  a_req_pulses: assert property ({FAULT_CLEAR_REQ, JOG_REQ, START_REQ, STOP_REQ} ==
    (CMD_STROBE ? LOGIC_COMMAND[3:0] : 4'h0)) else $error("request pulses wrong");
  a_aux_outs: assert property ($past(CE) && $past(RESETN) |->
    {OPTO1_OUT, OPTO2_OUT, RELAY_OUT} == $past(aux_want)) else $error("aux outputs wrong");
  a_accel_sel: assert property (CMD_STROBE && ^LOGIC_COMMAND[9:8] |-> ACCEL_RATE2 == LOGIC_COMMAND[9])
    else $error("accel select wrong");
  a_freq_src: assert property (CMD_STROBE && |LOGIC_COMMAND[14:12] |-> FREQ_SOURCE == LOGIC_COMMAND[14:12])
    else $error("frequency source wrong");
  a_ref_gate: assert property ($changed(SPEED_REFERENCE) |-> $past(SPEED_REFERENCE_SELECT) == 8'h05)
    else $error("reference stored while locked");
  a_exc_frozen: assert property (RSP_VALID && RSP_CODE != 8'h00 |->
    $stable(LOGIC_COMMAND) && $stable(SPEED_REFERENCE)) else $error("exception changed a register");
  c_strobe: cover property (CMD_STROBE);
  c_exception: cover property (RSP_VALID && RSP_CODE == 8'h01);
  c_relay: cover property (RELAY_OUT);
endmodule // mdci_cmd_if_chk

bind mdci_cmd_if mdci_cmd_if_chk i_chk (.CLK, .RESETN, .CE, .REQ_VALID, .REQ_READY, .REQ_FUNC, .RSP_VALID,
  .RSP_CODE, .START_SOURCE_SELECT, .SPEED_REFERENCE_SELECT, .OPTO1_OUTPUT_SELECT, .OPTO2_OUTPUT_SELECT,
  .RELAY_OUTPUT_SELECT, .FIRMWARE_REVISION, .LOGIC_COMMAND, .SPEED_REFERENCE, .CMD_STROBE, .STOP_REQ,
  .START_REQ, .JOG_REQ, .FAULT_CLEAR_REQ, .ACCEL_RATE2, .FREQ_SOURCE, .OPTO1_OUT, .OPTO2_OUT, .RELAY_OUT);

/* bench/mdci_cmd_if_tb.sv */
/*
  bench of the drive command interface: a master model sends table and
  random requests; expectations are worked out here.
  assumes the master model and bound checker are compiled first.
*/
module mdci_cmd_if_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] src_sel = 8'h05, ref_sel = 8'h05, o1_sel = 8'h14, o2_sel = 8'h14, rl_sel = 8'h14, s;
  logic [15:0] fw = 16'h0191;
  integer seed = 32'h4391;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] w, e_cmd, e_ref;
  logic ef, er, ea, ed;
  logic [2:0] es;
  logic [15:0] cw [4] = '{16'hffff, 16'h5555, 16'haaaa, 16'h0000};
  logic [47:0] rows [16] = '{48'h03_2000_0001_00, 48'h06_2000_0001_00, 48'h10_2000_0001_00,
    48'h01_2000_0001_01, 48'h02_2000_0001_01, 48'h04_2000_0001_01, 48'h05_2000_0001_01,
    48'h0f_2000_0001_01, 48'h17_2000_0001_01, 48'h2b_2000_0001_01, 48'hff_2000_0001_01,
    48'h10_2000_0003_03, 48'h03_2000_0000_03, 48'h03_2002_0001_02, 48'h06_1fff_0001_02, 48'h03_2001_0002_02};
  wire req_valid, req_ready, wr_valid, wr_ready, rd_valid, rsp_valid, fwd, rev, acc2, dec2, o1, o2, rly;
  wire stb, exc;
  wire [3:0] rq;
  wire [2:0] fsrc;
  wire [7:0] req_func, rsp_code;
  wire [15:0] req_addr, req_qty, req_data, wr_data, rd_data, logic_cmd, speed_ref;

  mdci_cmd_if i_dut (.CLK(clk), .RESETN(rst_n), .CE(ce), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_FUNC(req_func), .REQ_ADDR(req_addr), .REQ_QTY(req_qty), .REQ_DATA(req_data), .WR_VALID(wr_valid),
    .WR_READY(wr_ready), .WR_DATA(wr_data), .RD_VALID(rd_valid), .RD_DATA(rd_data), .RSP_VALID(rsp_valid),
    .RSP_EXCEPTION(exc), .RSP_CODE(rsp_code), .START_SOURCE_SELECT(src_sel), .SPEED_REFERENCE_SELECT(ref_sel),
    .OPTO1_OUTPUT_SELECT(o1_sel), .OPTO2_OUTPUT_SELECT(o2_sel), .RELAY_OUTPUT_SELECT(rl_sel),
    .FIRMWARE_REVISION(fw), .LOGIC_COMMAND(logic_cmd), .SPEED_REFERENCE(speed_ref), .CMD_STROBE(stb),
    .STOP_REQ(rq[0]), .START_REQ(rq[1]), .JOG_REQ(rq[2]), .FAULT_CLEAR_REQ(rq[3]), .DIR_FORWARD(fwd),
    .DIR_REVERSE(rev),
    .ACCEL_RATE2(acc2), .DECEL_RATE2(dec2), .FREQ_SOURCE(fsrc), .OPTO1_OUT(o1), .OPTO2_OUT(o2),
    .RELAY_OUT(rly));
  mdci_master i_mst (.clk, .req_valid, .req_ready, .req_func, .req_addr, .req_qty, .req_data, .wr_valid,
    .wr_ready, .wr_data, .rd_valid, .rd_data, .rsp_valid, .rsp_code);

  always #50 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end

  // new level of a two-bit select: 01 clears, 10 sets, else holds
  function automatic logic pick(logic [1:0] c, logic cur);
    return (c == 2'b01) ? 1'b0 : (c == 2'b10) ? 1'b1 : cur;
  endfunction

  task automatic take_cmd(logic [15:0] v);
    e_cmd = v;
    er = pick(v[5:4], er);
    ef = pick({v[4], v[5]}, ef);
    ea = pick(v[9:8], ea);
    ed = pick(v[11:10], ed);
    if (v[14:12] != 3'b000) es = v[14:12];
  endtask

  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic put(logic [7:0] f, logic [15:0] a, q, d0, d1, logic [7:0] ss, rs);
    src_sel <= ss;
    ref_sel <= rs;
    i_mst.xfer(f, a, q, d0, d1);
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {e_cmd, e_ref, ef, er, ea, ed, es} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // the three supported and eight bad function codes, bad counts and addresses, writes locked out
    foreach (rows[i]) begin
      put(rows[i][47:40], rows[i][39:24], rows[i][23:8], 16'($random(seed)), 16'hbeef, 8'h04, 8'h04);
      chk("code", rows[i][7:0], i_mst.code);
      chk("exception", rows[i][7:0] != 8'h00, exc);
      chk("kept", {e_cmd, e_ref}, {logic_cmd, speed_ref});
    end
    $display("function table done");
    // command words, corners then random, with locks, firmware and selects varied
    for (int i = 0; i < 40; i++) begin
      w = (i < 4) ? cw[i] : 16'($random(seed));
      s = (i > 3 && $random(seed) % 4 == 0) ? 8'h03 : 8'h05;
      fw <= 16'h0191 - 16'($random(seed) & 1);
      {o1_sel, o2_sel, rl_sel} <= {3{8'h14}} ^ (24'($random(seed)) & 24'h010101);
      if (i % 8 == 7) begin
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
      end
      put(8'h06, 16'h2000, 16'h0001, w, 16'h0000, s, 8'h05);
      if (s == 8'h05) take_cmd(w);
      chk("levels", {e_cmd, ef, er, ea, ed, es}, {logic_cmd, fwd, rev, acc2, dec2, fsrc});
      chk("pulses", {s == 8'h05, w[3:0] & {4{s == 8'h05}}}, {stb, rq});
      @(posedge clk);
      chk("aux", {3{fw >= 16'h0191}} & {o1_sel == 8'h14 && e_cmd[6], o2_sel == 8'h14 && e_cmd[7],
        rl_sel == 8'h14 && e_cmd[15]}, {o1, o2, rly});
    end
    $display("command test done");
    // reference writes, some locked out, each read back with the command
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 16'h0064 : 16'($random(seed));
      s = (i % 3 == 2) ? 8'h00 : 8'h05;
      put(8'h06, 16'h2001, 16'h0001, w, 16'h0000, 8'h05, s);
      if (s == 8'h05) e_ref = w;
      chk("reference", e_ref, speed_ref);
      put(8'h03, 16'h2000, 16'h0002, 16'h0000, 16'h0000, 8'h05, 8'h05);
      chk("read", {e_cmd, e_ref}, {i_mst.rd[0], i_mst.rd[1]});
    end
    // both registers in one multiple write
    w = 16'($random(seed));
    put(8'h10, 16'h2000, 16'h0002, w, 16'h0123, 8'h05, 8'h05);
    take_cmd(w);
    e_ref = 16'h0123;
    chk("multi", {e_cmd, e_ref}, {logic_cmd, speed_ref});
    $display("reference test done");
    // reset in mid-run clears both registers
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset", 32'h0, {logic_cmd, speed_ref});
    chk("reset levels", 32'h0, {fwd, rev, acc2, dec2, fsrc, o1, o2, rly, stb, rq});
    $display("reset test done");
    end_of_test();
  end
endmodule // mdci_cmd_if_tb
